// file: src/dmt_mem.sv
// data memory access unit: two bus masters, four memory sets, i/o protection
// assumes masters hold a request stable until its done pulse
//
// Behaviour
// R1 - every i/o location reachable by load and store accesses
// R2 - direct i/o accesses reach locations 0x00 to 0x3f without data decode
// R3 - bit set, clear and test in one cycle for i/o 0x00 to 0x1f
// R4 - lowest 16 i/o addresses are plain general purpose storage
// R5 - four memory sets; masters on different sets proceed concurrently
// R6 - i/o read or write completes in one cycle
// R7 - sram write takes one cycle, sram read two cycles
// R8 - eeprom page buffer load one cycle, eeprom read three cycles
// R9 - burst reads deliver a new item every second cycle; code gives one every fourth cycle (two-cycle burst read plus done and accept)
// R10 - lock set blocks writes to clock, event and waveform registers
// R11 - lock register written only inside the timed unlock window
// R12 - readable three byte identity plus separate revision register
// R13 - flash programmed per page, read one byte per access
// R14 - flash page 128 words: low pointer bits word, bit 7 up page
// R15 - eeprom written or erased per page or per byte, read per byte
// R16 - eeprom page 32 bytes: bits 4..0 byte, bits 10..5 page
// R17 - program counter width follows flash size, 14 to 17 bits
// R18 - mapped eeprom starts at data address 0x1000
// R19 - writes to locked registers silently dropped, no error
`timescale 1ns/100ps
`default_nettype none
`include "dmt_cfg.svh"
module dmt_mem
  import dmt_pkg::*;
#(
  // identity values below are arbitrary
  parameter logic [23:0] DEV_ID = 24'h5a3c01,
  parameter logic [7:0] DEV_REV = 8'h01
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // bus masters, index 0 has priority
  input wire logic [1:0] req_valid_i,
  input wire dmt_req_s req_i [2],
  output dmt_rsp_s rsp_o [2],
  // nonvolatile memory command and pointer
  input wire dmt_nvm_e nvm_cmd_i,
  input wire logic [`DMT_PC_BITS-1:0] nvm_ptr_i,
  output logic [`DMT_PC_BITS-`DMT_FLASH_WORD_IN_PAGE_BITS-1:0] flash_page_number_o,
  output logic [`DMT_FLASH_WORD_IN_PAGE_BITS-1:0] flash_word_in_page_o,
  output logic [`DMT_EADDR_BITS-`DMT_EBYTE_BITS-1:0] eeprom_page_number_o,
  output logic [`DMT_EBYTE_BITS-1:0] eeprom_byte_in_page_o,
  // protection state
  output logic lock_o
);

  localparam int CCPW = 4;
  localparam logic [CCPW-1:0] CCP_LOAD = CCPW'((`DMT_CCP_CYCLES < 1) ? 1 : `DMT_CCP_CYCLES);

  function automatic dmt_set_e set_of(input logic [15:0] a);
    if (a >= `DMT_SRAM_MID && a <= `DMT_SRAM_END) set_of = DMT_SET_SRAM1;
    else if (a >= `DMT_SRAM_BASE && a < `DMT_SRAM_MID) set_of = DMT_SET_SRAM0;
    else if (a >= `DMT_EE_BASE && a < `DMT_EE_BASE + 16'(`DMT_EE_SIZE)) set_of = DMT_SET_EE; // R18
    else set_of = DMT_SET_IO;
  endfunction

  // effective address; direct accesses skip the data address decode
  function automatic logic [15:0] eff_addr(input dmt_req_s r);
    eff_addr = r.io_direct ? {10'h000, r.addr[5:0]} : r.addr; // R2
  endfunction

  function automatic logic is_prot(input logic [15:0] a);
    is_prot = (a >= `DMT_CLK_BASE && a < `DMT_CLK_BASE + 16'(`DMT_PROT_SIZE))
           || (a >= `DMT_EVT_BASE && a < `DMT_EVT_BASE + 16'(`DMT_PROT_SIZE))
           || (a >= `DMT_WEX_BASE && a < `DMT_WEX_BASE + 16'(`DMT_PROT_SIZE));
  endfunction

  function automatic logic [4:0] prot_idx(input logic [15:0] a);
    if (a >= `DMT_WEX_BASE) prot_idx = {2'b10, a[2:0]};
    else if (a >= `DMT_EVT_BASE) prot_idx = {2'b01, a[2:0]};
    else prot_idx = {2'b00, a[2:0]};
  endfunction

  function automatic logic is_write(input dmt_op_e op);
    is_write = (op == DMT_OP_WRITE);
  endfunction

  // cycles from acceptance to done
  function automatic logic [1:0] lat_of(input dmt_set_e s, input dmt_op_e op, input logic cont);
    if (s == DMT_SET_IO) lat_of = `DMT_LAT_IO; // R6
    else if (is_write(op)) lat_of = `DMT_LAT_WRITE; // R7 R8
    else if (s == DMT_SET_EE) lat_of = cont ? `DMT_LAT_BURST : `DMT_LAT_EE_RD; // R8 R9
    else lat_of = `DMT_LAT_SRAM_RD; // R7
  endfunction

  logic [7:0] io_q [`DMT_IO_LOW_SIZE];
  logic [7:0] prot_q [3*`DMT_PROT_SIZE];
  logic [7:0] ee_q [`DMT_EE_SIZE];
  logic [7:0] eebuf_q [`DMT_EE_PAGE];
  logic [`DMT_EE_PAGE-1:0] eemask_q;
  logic [7:0] sram_q [`DMT_SRAM_SIZE];
  logic lock_q;
  logic [CCPW-1:0] ccp_q;
  logic [1:0] busy_q;
  logic [1:0] cnt_q [2];
  dmt_req_s cur_q [2];
  logic [1:0] ee_rd_q;
  dmt_rsp_s rsp_q [2];
  logic [1:0] acc;
  logic [15:0] ea [2];
  dmt_set_e st [2];
  dmt_set_e cur_set [2];

  function automatic logic [7:0] io_read(input logic [15:0] a);
    if (a < 16'(`DMT_IO_LOW_SIZE)) io_read = io_q[a[5:0]]; // R1 R4
    else if (is_prot(a)) io_read = prot_q[prot_idx(a)];
    else if (a == `DMT_LOCK_ADDR) io_read = {7'h00, lock_q};
    else if (a >= `DMT_ID_ADDR && a < `DMT_REV_ADDR) io_read = DEV_ID[8*a[1:0] +: 8]; // R12
    else if (a == `DMT_REV_ADDR) io_read = DEV_REV; // R12
    else io_read = 8'h00;
  endfunction

  // a call result cannot be indexed directly, so the byte goes through a local first
  function automatic logic bit_of(input logic [15:0] a, input logic [2:0] b);
    logic [7:0] v;
    v = io_read(a);
    bit_of = v[b];
  endfunction

  // acceptance and set arbitration
  always_comb begin
    for (int m = 0; m < 2; m++) begin
      ea[m] = eff_addr(req_i[m]);
      st[m] = set_of(ea[m]);
      cur_set[m] = set_of(eff_addr(cur_q[m]));
    end
    acc[0] = req_valid_i[0] && !busy_q[0] && !rsp_q[0].done && !(busy_q[1] && cur_set[1] == st[0]); // R5
    acc[1] = req_valid_i[1] && !busy_q[1] && !rsp_q[1].done && !(busy_q[0] && cur_set[0] == st[1])
          && !(acc[0] && st[0] == st[1]); // R5
  end

  // per-master sequencing
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 2'b00;
      ee_rd_q <= 2'b00;
      for (int m = 0; m < 2; m++) begin
        cnt_q[m] <= 2'h0;
        cur_q[m] <= '0;
        rsp_q[m] <= '0;
      end
    end else begin
      for (int m = 0; m < 2; m++) begin
        rsp_q[m].done <= 1'b0;
        if (acc[m]) begin
          busy_q[m] <= 1'b1;
          cur_q[m] <= req_i[m];
          cnt_q[m] <= lat_of(st[m], req_i[m].op, req_i[m].burst && ee_rd_q[m]) - 2'h1;
          ee_rd_q[m] <= (st[m] == DMT_SET_EE) && !is_write(req_i[m].op);
        end else if (busy_q[m]) begin
          if (cnt_q[m] == 2'h0) begin
            busy_q[m] <= 1'b0;
            rsp_q[m].done <= 1'b1;
            case (cur_set[m])
              DMT_SET_IO: rsp_q[m].rdata <= io_read(eff_addr(cur_q[m]));
              DMT_SET_EE: rsp_q[m].rdata <= ee_q[11'(eff_addr(cur_q[m]) - `DMT_EE_BASE)]; // R15
              DMT_SET_SRAM0, DMT_SET_SRAM1: rsp_q[m].rdata <= sram_q[13'(eff_addr(cur_q[m]) - `DMT_SRAM_BASE)];
              default: rsp_q[m].rdata <= 8'h00;
            endcase
            rsp_q[m].bit_val <= bit_of(eff_addr(cur_q[m]), cur_q[m].wdata[2:0]); // R3
          end else begin
            cnt_q[m] <= cnt_q[m] - 2'h1;
          end
        end else if (!req_valid_i[m]) begin
          ee_rd_q[m] <= 1'b0;
        end
      end
    end
  end

  // i/o space writes, bit operations and protection
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `DMT_IO_LOW_SIZE; i++) io_q[i] <= 8'h00;
      for (int i = 0; i < 3*`DMT_PROT_SIZE; i++) prot_q[i] <= 8'h00;
      lock_q <= 1'b0;
      ccp_q <= '0;
    end else begin
      if (ccp_q != '0) ccp_q <= ccp_q - CCPW'(1);
      for (int m = 0; m < 2; m++) begin
        if (acc[m] && st[m] == DMT_SET_IO) begin
          case (req_i[m].op)
            DMT_OP_WRITE: begin
              if (ea[m] < 16'(`DMT_IO_LOW_SIZE)) io_q[ea[m][5:0]] <= req_i[m].wdata; // R1 R4
              else if (is_prot(ea[m]) && !lock_q) prot_q[prot_idx(ea[m])] <= req_i[m].wdata; // R10 R19
              else if (ea[m] == `DMT_LOCK_ADDR && ccp_q != '0) lock_q <= req_i[m].wdata[0]; // R11 R19
              else if (ea[m] == `DMT_CCP_ADDR && req_i[m].wdata == `DMT_CCP_KEY) ccp_q <= CCP_LOAD; // R11
            end
            DMT_OP_SETBIT: begin
              if (ea[m] <= `DMT_IO_BITOP_LAST) io_q[ea[m][5:0]][req_i[m].wdata[2:0]] <= 1'b1; // R3
            end
            DMT_OP_CLRBIT: begin
              if (ea[m] <= `DMT_IO_BITOP_LAST) io_q[ea[m][5:0]][req_i[m].wdata[2:0]] <= 1'b0; // R3
            end
            default: ;
          endcase
        end
      end
    end
  end

  // sram stores; the two halves are separate sets so both masters may write at once
  always_ff @(posedge clk_i) begin
    for (int m = 0; m < 2; m++) begin
      if (acc[m] && is_write(req_i[m].op) && (st[m] == DMT_SET_SRAM0 || st[m] == DMT_SET_SRAM1))
        sram_q[13'(ea[m] - `DMT_SRAM_BASE)] <= req_i[m].wdata; // R7
    end
  end

  // mapped eeprom stores load the page buffer only; the array changes on commands
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      eemask_q <= '0;
      for (int i = 0; i < `DMT_EE_PAGE; i++) eebuf_q[i] <= 8'hff;
    end else begin
      if (nvm_cmd_i != DMT_NVM_NONE) eemask_q <= '0;
      for (int m = 0; m < 2; m++) begin
        if (acc[m] && is_write(req_i[m].op) && st[m] == DMT_SET_EE) begin
          eebuf_q[ea[m][4:0]] <= req_i[m].wdata; // R8
          eemask_q[ea[m][4:0]] <= 1'b1;
        end
      end
    end
  end

  // eeprom array: byte or page granularity, page chosen by bits 10..5
  always_ff @(posedge clk_i) begin
    case (nvm_cmd_i)
      DMT_NVM_EE_WRITE_BYTE: ee_q[nvm_ptr_i[10:0]] <= eebuf_q[nvm_ptr_i[4:0]]; // R15
      DMT_NVM_EE_ERASE_BYTE: ee_q[nvm_ptr_i[10:0]] <= 8'hff; // R15
      DMT_NVM_EE_WRITE_PAGE: begin
        for (int i = 0; i < `DMT_EE_PAGE; i++)
          if (eemask_q[i]) ee_q[{nvm_ptr_i[10:5], 5'(i)}] <= eebuf_q[i]; // R15 R16
      end
      DMT_NVM_EE_ERASE_PAGE: begin
        for (int i = 0; i < `DMT_EE_PAGE; i++) ee_q[{nvm_ptr_i[10:5], 5'(i)}] <= 8'hff; // R15 R16
      end
      default: ;
    endcase
  end

  // flash programming acts on whole pages, so only the split is produced here
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flash_page_number_o <= '0;
      flash_word_in_page_o <= '0;
      eeprom_page_number_o <= '0;
      eeprom_byte_in_page_o <= '0;
    end else begin
      flash_word_in_page_o <= nvm_ptr_i[`DMT_FLASH_WORD_IN_PAGE_BITS-1:0]; // R13 R14
      flash_page_number_o <= nvm_ptr_i[`DMT_PC_BITS-1:`DMT_FLASH_WORD_IN_PAGE_BITS]; // R14 R17
      eeprom_byte_in_page_o <= nvm_ptr_i[`DMT_EBYTE_BITS-1:0]; // R16
      eeprom_page_number_o <= nvm_ptr_i[`DMT_EADDR_BITS-1:`DMT_EBYTE_BITS]; // R16
    end
  end

  assign rsp_o = rsp_q;
  assign lock_o = lock_q;

endmodule // dmt_mem
`default_nettype wire

// file: src/dmt_cfg.svh
// constants of the data memory access block: address windows, sizes, latencies
// assumes inclusion by the package and the design file by bare name
`ifndef DMT_CFG_SVH
`define DMT_CFG_SVH
`define DMT_IO_DIRECT_LAST 16'h003f
`define DMT_IO_BITOP_LAST 16'h001f
`define DMT_GPR_COUNT 16
`define DMT_IO_LOW_SIZE 64
`define DMT_CLK_BASE 16'h0040
`define DMT_EVT_BASE 16'h0180
`define DMT_WEX_BASE 16'h0880
`define DMT_PROT_SIZE 8
`define DMT_LOCK_ADDR 16'h0048
`define DMT_CCP_ADDR 16'h0049
`define DMT_CCP_KEY 8'ha5
`define DMT_CCP_TIME_NS 100
`define DMT_CLK_PERIOD_NS 25
`define DMT_CCP_CYCLES ((`DMT_CCP_TIME_NS) / (`DMT_CLK_PERIOD_NS))
`define DMT_ID_ADDR 16'h0090
`define DMT_REV_ADDR 16'h0093
`define DMT_EE_BASE 16'h1000
`define DMT_EE_SIZE 2048
`define DMT_EE_PAGE 32
`define DMT_SRAM_BASE 16'h2000
`define DMT_SRAM_MID 16'h3000
`define DMT_SRAM_END 16'h3fff
`define DMT_SRAM_SIZE 8192
`define DMT_LAT_IO 2'h1
`define DMT_LAT_WRITE 2'h1
`define DMT_LAT_SRAM_RD 2'h2
`define DMT_LAT_EE_RD 2'h3
`define DMT_LAT_BURST 2'h2
`define DMT_PC_BITS 17
`define DMT_FLASH_WORD_IN_PAGE_BITS 7
`define DMT_EBYTE_BITS 5
`define DMT_EADDR_BITS 11
`endif

// file: src/dmt_pkg.sv
// types of the data memory access block
// assumes dmt_cfg.svh on the include path
`include "dmt_cfg.svh"
package dmt_pkg;
  typedef enum logic [2:0] {
    DMT_OP_READ = 3'b000,
    DMT_OP_WRITE = 3'b001,
    DMT_OP_SETBIT = 3'b010,
    DMT_OP_CLRBIT = 3'b011,
    DMT_OP_TESTBIT = 3'b100
  } dmt_op_e;
  typedef enum logic [1:0] {
    DMT_SET_IO = 2'b00,
    DMT_SET_EE = 2'b01,
    DMT_SET_SRAM0 = 2'b10,
    DMT_SET_SRAM1 = 2'b11
  } dmt_set_e;
  typedef enum logic [2:0] {
    DMT_NVM_NONE = 3'b000,
    DMT_NVM_EE_WRITE_BYTE = 3'b001,
    DMT_NVM_EE_ERASE_BYTE = 3'b010,
    DMT_NVM_EE_WRITE_PAGE = 3'b011,
    DMT_NVM_EE_ERASE_PAGE = 3'b100
  } dmt_nvm_e;
  typedef struct packed {
    logic io_direct;
    dmt_op_e op;
    logic burst;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dmt_req_s;
  typedef struct packed {
    logic done;
    logic bit_val;
    logic [7:0] rdata;
  } dmt_rsp_s;
endpackage : dmt_pkg

// file: verif/dmt_mem_asserts.sv
// checker of the data memory access block, sees only the top ports
// assumes binding to dmt_mem; master 1 stays off i/o, sram0 and eeprom
`timescale 1ns/100ps
`default_nettype none
module dmt_mem_asserts
  import dmt_pkg::*;
(
  // watched ports
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] req_valid_i,
  input wire dmt_req_s req_i [2],
  input wire dmt_rsp_s rsp_o [2],
  input wire logic [16:0] nvm_ptr_i,
  input wire logic [9:0] flash_page_number_o,
  input wire logic [6:0] flash_word_in_page_o,
  input wire logic [5:0] eeprom_page_number_o,
  input wire logic [4:0] eeprom_byte_in_page_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [1:0] v_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      v_q <= 2'h0;
    end else begin
      v_q <= req_valid_i;
    end
  end
  // a fresh request is taken at once while the other master is quiet
  wire logic go0 = req_valid_i[0] & ~v_q[0] & ~req_valid_i[1];
  wire logic io0 = req_i[0].io_direct | (req_i[0].addr[15:12] == 4'h0);
  wire logic sr0 = ~req_i[0].io_direct & (req_i[0].addr[15:13] == 3'h1);
  wire logic ee0 = ~req_i[0].io_direct & (req_i[0].addr[15:11] == 5'h02);
  wire logic rd0 = req_i[0].op == DMT_OP_READ;
  wire logic both = (req_valid_i == 2'h3) & (v_q == 2'h0) & rd0 & (req_i[1].op == DMT_OP_READ)
    & ~req_i[0].io_direct & ~req_i[1].io_direct & (req_i[0].addr[15:12] == 4'h2) & (req_i[1].addr[15:12] == 4'h3);
  property p_io; go0 && io0 |=> !rsp_o[0].done ##1 rsp_o[0].done; endproperty
  a_io: assert property (p_io) else $error("i/o access not done in one cycle");
  property p_srd; go0 && sr0 && rd0 |=> !rsp_o[0].done [*2] ##1 rsp_o[0].done; endproperty
  a_srd: assert property (p_srd) else $error("sram read not done in two cycles");
  property p_wr; go0 && (sr0 || ee0) && req_i[0].op == DMT_OP_WRITE |=> !rsp_o[0].done ##1 rsp_o[0].done; endproperty
  a_wr: assert property (p_wr) else $error("memory write not done in one cycle");
  property p_erd; go0 && ee0 && rd0 |=> !rsp_o[0].done [*3] ##1 rsp_o[0].done; endproperty
  a_erd: assert property (p_erd) else $error("eeprom read not done in three cycles");
  property p_conc; both |-> ##3 (rsp_o[0].done && rsp_o[1].done); endproperty
  a_conc: assert property (p_conc) else $error("sram sets blocked each other");
  property p_pulse; rsp_o[0].done |=> !rsp_o[0].done; endproperty
  a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
  property p_fl; 1'b1 |=> {flash_page_number_o, flash_word_in_page_o} == $past(nvm_ptr_i); endproperty
  a_fl: assert property (p_fl) else $error("flash page split wrong");
  property p_ee; 1'b1 |=> {eeprom_page_number_o, eeprom_byte_in_page_o} == $past(nvm_ptr_i[10:0]); endproperty
  a_ee: assert property (p_ee) else $error("eeprom page split wrong");
  c_io: cover property (go0 && io0);
  c_conc: cover property (both);
  c_erd: cover property (go0 && ee0 && rd0);
endmodule // dmt_mem_asserts
`default_nettype wire

// file: verif/dmt_master.sv
// bus master model standing in for the cpu core
// assumes the bench calls xfer from its scenarios, one call at a time per master
`timescale 1ns/100ps
`default_nettype none
module dmt_master
  import dmt_pkg::*;
(
  // clock
  input wire logic clk_i,
  // request and answer
  output logic valid_o,
  output dmt_req_s req_o,
  input wire dmt_rsp_s rsp_i
);
  initial begin
    valid_o = 1'b0;
    req_o = '0;
  end
  // request held until done is seen; a released bus shows the inverse, not stale values
  task automatic xfer(input logic io, input dmt_op_e op, input logic [15:0] a, input logic [7:0] wd,
                      output logic [7:0] lat, output logic [7:0] rd, output logic bv);
    int n;
    n = 0;
    @(negedge clk_i);
    req_o = '{io, op, 1'b0, a, wd};
    valid_o = 1'b1;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (rsp_i.done !== 1'b1 && n < 40);
    // the first edge only takes the request; latency counts from there
    lat = 8'(n - 1);
    rd = rsp_i.rdata;
    bv = rsp_i.bit_val;
    @(negedge clk_i);
    valid_o = 1'b0;
    req_o = dmt_req_s'(~req_o);
  endtask
endmodule // dmt_master
`default_nettype wire

// file: verif/dmt_mem_test.sv
// bench top of the data memory access block: two master models, checker bound
// assumes dmt_mem, dmt_master and dmt_mem_asserts compiled before it
`timescale 1ns/100ps
`default_nettype none
module dmt_mem_test;
  import dmt_pkg::*;
  // identity values are arbitrary
  localparam logic [23:0] ID = 24'hc3d2e1;
  localparam logic [7:0] REV = 8'h4b;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  wire logic [1:0] req_valid_i;
  wire dmt_req_s req_i [2];
  wire dmt_rsp_s rsp_o [2];
  dmt_nvm_e nvm_cmd_i = DMT_NVM_NONE;
  logic [16:0] nvm_ptr_i = '0;
  logic [9:0] fpg;
  logic [6:0] fwd;
  logic [5:0] epg;
  logic [4:0] eby;
  logic lock_o;
  logic [7:0] lat, rd, lat1, rd1;
  logic bv, bv1;
  logic [15:0] prot [3] = '{16'h0040, 16'h0180, 16'h0880};
  int fail_count = 0;
  int n_checks = 0;
  always #12.5 clk_i = ~clk_i;
  dmt_mem #(.DEV_ID(ID), .DEV_REV(REV)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .rsp_o(rsp_o), .nvm_cmd_i(nvm_cmd_i), .nvm_ptr_i(nvm_ptr_i), .flash_page_number_o(fpg),
    .flash_word_in_page_o(fwd), .eeprom_page_number_o(epg), .eeprom_byte_in_page_o(eby), .lock_o(lock_o));
  dmt_master m0 (.clk_i(clk_i), .valid_o(req_valid_i[0]), .req_o(req_i[0]), .rsp_i(rsp_o[0]));
  dmt_master m1 (.clk_i(clk_i), .valid_o(req_valid_i[1]), .req_o(req_i[1]), .rsp_i(rsp_o[1]));
  task automatic chk(input string what, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic acc(input logic io, input dmt_op_e op, input logic [15:0] a, input logic [7:0] wd);
    m0.xfer(io, op, a, wd, lat, rd, bv);
  endtask
  task automatic cmd(input dmt_nvm_e c, input logic [16:0] p);
    @(negedge clk_i);
    nvm_cmd_i = c;
    nvm_ptr_i = p;
    @(negedge clk_i);
    nvm_cmd_i = DMT_NVM_NONE;
  endtask
  task automatic t_io();
    acc(1'b0, DMT_OP_WRITE, 16'h000f, 8'h5a);
    chk("gp write latency", 8'h01, lat);
    acc(1'b0, DMT_OP_SETBIT, 16'h000f, 8'h07);
    acc(1'b0, DMT_OP_CLRBIT, 16'h000f, 8'h01);
    acc(1'b1, DMT_OP_READ, 16'h000f, 8'h00);
    chk("gp direct read", 8'hd8, rd);
    acc(1'b0, DMT_OP_TESTBIT, 16'h000f, 8'h07);
    chk("test bit", 1'b1, bv);
    chk("test bit latency", 8'h01, lat);
    acc(1'b0, DMT_OP_WRITE, 16'h0020, 8'h00);
    acc(1'b0, DMT_OP_SETBIT, 16'h0020, 8'h00);
    acc(1'b0, DMT_OP_READ, 16'h0020, 8'h00);
    chk("bit op above range", 8'h00, rd);
    $display("t_io finished");
  endtask
  task automatic t_sram();
    acc(1'b0, DMT_OP_WRITE, 16'h2000, 8'h11);
    chk("sram write latency", 8'h01, lat);
    m1.xfer(1'b0, DMT_OP_WRITE, 16'h3fff, 8'h22, lat1, rd1, bv1);
    fork
      m0.xfer(1'b0, DMT_OP_READ, 16'h2000, 8'h00, lat, rd, bv);
      m1.xfer(1'b0, DMT_OP_READ, 16'h3fff, 8'h00, lat1, rd1, bv1);
    join
    chk("sram read latency", 8'h02, lat);
    chk("parallel read latency", 8'h02, lat1);
    chk("sram0 data", 8'h11, rd);
    chk("sram1 data", 8'h22, rd1);
    $display("t_sram finished");
  endtask
  task automatic t_ee();
    acc(1'b0, DMT_OP_WRITE, 16'h1005, 8'h77);
    chk("page buffer load latency", 8'h01, lat);
    cmd(DMT_NVM_EE_WRITE_BYTE, 17'h00005);
    acc(1'b0, DMT_OP_READ, 16'h1005, 8'h00);
    chk("eeprom read latency", 8'h03, lat);
    chk("eeprom byte", 8'h77, rd);
    cmd(DMT_NVM_EE_ERASE_BYTE, 17'h00005);
    acc(1'b0, DMT_OP_READ, 16'h1005, 8'h00);
    chk("erased byte", 8'hff, rd);
    acc(1'b0, DMT_OP_WRITE, 16'h103f, 8'h3c);
    cmd(DMT_NVM_EE_WRITE_PAGE, 17'h00020);
    acc(1'b0, DMT_OP_READ, 16'h103f, 8'h00);
    chk("page written byte", 8'h3c, rd);
    cmd(DMT_NVM_NONE, 17'h1abcd);
    chk("flash split", 17'h1abcd, {fpg, fwd});
    chk("eeprom split", 11'h3cd, {epg, eby});
    $display("t_ee finished");
  endtask
  task automatic t_lock();
    foreach (prot[i]) acc(1'b0, DMT_OP_WRITE, prot[i], 8'h33);
    acc(1'b0, DMT_OP_WRITE, 16'h0048, 8'h01);
    chk("lock without key", 1'b0, lock_o);
    acc(1'b0, DMT_OP_WRITE, 16'h0049, 8'ha5);
    acc(1'b0, DMT_OP_WRITE, 16'h0048, 8'h01);
    chk("lock with key", 1'b1, lock_o);
    foreach (prot[i]) begin
      acc(1'b0, DMT_OP_WRITE, prot[i], 8'h44);
      chk("locked write done", 8'h01, lat);
      acc(1'b0, DMT_OP_READ, prot[i], 8'h00);
      chk("locked register", 8'h33, rd);
    end
    acc(1'b0, DMT_OP_WRITE, 16'h0049, 8'ha5);
    acc(1'b0, DMT_OP_WRITE, 16'h0048, 8'h00);
    acc(1'b0, DMT_OP_WRITE, 16'h0180, 8'h44);
    acc(1'b0, DMT_OP_READ, 16'h0180, 8'h00);
    chk("unlocked register", 8'h44, rd);
    $display("t_lock finished");
  endtask
  task automatic t_id();
    for (int i = 0; i < 3; i++) begin
      acc(1'b0, DMT_OP_READ, 16'h0090 + 16'(i), 8'h00);
      chk("identity byte", ID[8*i+:8], rd);
    end
    acc(1'b0, DMT_OP_READ, 16'h0093, 8'h00);
    chk("revision", REV, rd);
    $display("t_id finished");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    t_io();
    t_sram();
    t_ee();
    t_lock();
    t_id();
    stop_test();
  end
  // the scenarios need well under 400 cycles
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
endmodule // dmt_mem_test
bind dmt_mem dmt_mem_asserts u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
  .rsp_o(rsp_o), .nvm_ptr_i(nvm_ptr_i), .flash_page_number_o(flash_page_number_o),
  .flash_word_in_page_o(flash_word_in_page_o), .eeprom_page_number_o(eeprom_page_number_o),
  .eeprom_byte_in_page_o(eeprom_byte_in_page_o));
`default_nettype wire
